// >>> core/pswr_pkg.sv
// Functional notes
// - 24-bit sweep step size, reset 800h
// - 24-bit sweep step count, reset 800h
// - 24-bit dwell at ramp ends, reset 800h
// - aux clock source select, four inputs
// - aux clock path select, four paths
// - aux divide ratio field, reset 010
// - aux clock feeds modulator when set
// - enable bit runs 10-bit LFSR
// - enable bit runs 8-bit accumulator
// - delay modulation mode, four choices
// - accumulator wrap toggles square wave
// - low and high delay levels, high 7
// - invert selects aux edge that ticks modulator; ring may clock LFSR
// - lock once count reaches threshold 40h
// - asymmetric lock window and its polarity
// - auto lock on readout pin when idle
// - fixed lock on readout pin, no reads
// - output source select drives three pins
// - select 0000 drives static value field
// - driver enable gates all output pads
// - per-pad disable mask for drivers
`default_nettype none
package pswr_pkg;
   localparam logic [5:0]  ADDR_SWEEP_INC = 6'h15;
   localparam logic [5:0]  ADDR_SWEEP_CNT = 6'h16;
   localparam logic [5:0]  ADDR_DWELL     = 6'h17;
   localparam logic [5:0]  ADDR_AUX_A     = 6'h18;
   localparam logic [5:0]  ADDR_AUX_B     = 6'h19;
   localparam logic [5:0]  ADDR_LOCK      = 6'h1A;
   localparam logic [5:0]  ADDR_GPO       = 6'h1B;
   localparam logic [23:0] RST_SWEEP      = 24'h000800;
   localparam logic [23:0] RST_AUX_A      = 24'h0000A0;
   localparam logic [23:0] RST_AUX_B      = 24'h00000F;
   localparam logic [23:0] RST_LOCK       = 24'h001040;
   localparam logic [23:0] RST_GPO        = 24'h000000;
   localparam logic [9:0]  LFSR_SEED      = 10'h001;
   localparam logic [4:0]  HDR_BITS       = 5'h07;
   localparam logic [4:0]  FRAME_BITS     = 5'h1F;
   localparam int AUXA_INSEL  = 0;
   localparam int AUXA_PATH   = 2;
   localparam int AUXA_DIV    = 4;
   localparam int AUXA_DSMSEL = 7;
   localparam int AUXA_LFSR   = 8;
   localparam int AUXA_ACC    = 9;
   localparam int AUXA_MODE   = 10;
   localparam int AUXA_STEP   = 12;
   localparam int AUXA_LODLY  = 20;
   localparam int AUXB_HIDLY  = 0;
   localparam int AUXB_INV    = 3;
   localparam int AUXB_RING   = 4;
   localparam int LKD_THR     = 0;
   localparam int LKD_ASYM    = 10;
   localparam int LKD_POL     = 11;
   localparam int LKD_AUTO    = 12;
   localparam int LKD_FIXED   = 13;
   localparam int GPO_SEL     = 0;
   localparam int GPO_STATIC  = 4;
   localparam int GPO_DRV     = 7;
   localparam int GPO_DIS     = 8;
   localparam logic [3:0] GSEL_STATIC = 4'h0;
   localparam logic [3:0] GSEL_CLOCKS = 4'h1;
   localparam logic [3:0] GSEL_PFD    = 4'h2;
   localparam logic [3:0] GSEL_XREF   = 4'h4;
   localparam logic [3:0] GSEL_AUX    = 4'h7;
   localparam logic [3:0] GSEL_RAMP   = 4'h8;
   localparam logic [1:0] DMOD_PASS   = 2'h0;
   localparam logic [1:0] DMOD_SQUARE = 2'h1;
   localparam logic [1:0] DMOD_LFSR_LO = 2'h2;
   localparam logic [1:0] DMOD_LFSR_HI = 2'h3;
   localparam int CLK_MHZ      = 25;
   localparam int ASYM_WIN_NS  = 10;
   localparam int ASYM_WIN_RAW = ASYM_WIN_NS * CLK_MHZ / 1000;
   localparam int ASYM_WIN_CYC = (ASYM_WIN_RAW < 1) ? 1 : ASYM_WIN_RAW;
   typedef struct packed {
      logic sck;
      logic sen;
      logic sdi;
      logic vco;
      logic refc;
      logic xref;
      logic xsin;
      logic ring;
      logic up;
      logic dn;
      logic busy;
   } pswr_pins_s;
endpackage
`default_nettype wire

// >>> core/pswr_mod_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pswr_mod_if;
   logic       tick;
   logic       lfsr_tick;
   logic       lfsr_en;
   logic       accum_en;
   logic [1:0] mode;
   logic [7:0] step;
   logic [2:0] lodly;
   logic [2:0] hidly;
   logic [2:0] delay;
   modport ctl (output tick, lfsr_tick, lfsr_en, accum_en, mode, step, lodly, hidly,
                input delay);
   modport mod (input tick, lfsr_tick, lfsr_en, accum_en, mode, step, lodly, hidly,
                output delay);
endinterface
`default_nettype wire

// >>> core/pswr_dlymod.sv
`timescale 1ns/1ps
`default_nettype none
module pswr_dlymod (
   input  wire logic core_clk,
   input  wire logic rst_b,
   pswr_mod_if.mod   m
);
   typedef struct packed {
      logic [7:0] acc;
      logic       sq;
      logic [9:0] lfsr;
      logic [2:0] dly;
   } pswr_mod_s;

   pswr_mod_s  q;
   pswr_mod_s  d;
   logic [8:0] sum;

   always_comb begin
      d = q;
      sum = {1'b0, q.acc} + {1'b0, m.step};
      if (m.accum_en && m.tick) begin
         d.acc = sum[7:0];
         if (sum[8]) begin
            d.sq = ~q.sq;
         end
      end
      if (m.lfsr_en && m.lfsr_tick) begin
         d.lfsr = {q.lfsr[8:0], q.lfsr[9] ^ q.lfsr[6]};
      end
      unique case (m.mode)
         pswr_pkg::DMOD_PASS:    d.dly = m.lodly;
         pswr_pkg::DMOD_SQUARE:  d.dly = q.sq ? m.hidly : m.lodly;
         pswr_pkg::DMOD_LFSR_LO: d.dly = m.lodly ^ {2'b00, q.lfsr[0]};
         pswr_pkg::DMOD_LFSR_HI: d.dly = q.lfsr[2:0];
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.lfsr <= pswr_pkg::LFSR_SEED;
      end else begin
         q <= d;
      end
   end

   assign m.delay = q.dly;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   acc_wrap_tog_a: assert property (m.accum_en && m.tick && sum[8] |=> q.sq != $past(q.sq))
      else $error("square wave missed accumulator wrap");
   lfsr_step_a: assert property (m.lfsr_en && m.lfsr_tick |=> q.lfsr != $past(q.lfsr))
      else $error("lfsr did not advance");
   acc_hold_a: assert property (!m.accum_en |=> $stable(q.acc))
      else $error("accumulator moved while disabled");
   pass_dly_a: assert property (m.mode == pswr_pkg::DMOD_PASS |=> q.dly == $past(m.lodly))
      else $error("pass mode delay not low value");
endmodule
`default_nettype wire

// >>> core/pswr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pswr_regs #(
   parameter int SYM_WIN_CYC = 2
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        ser_clk,
   input  wire logic        ser_enable,
   input  wire logic        ser_data_in,
   input  wire logic        vco_div_clk,
   input  wire logic        ref_clk,
   input  wire logic        xref_clk,
   input  wire logic        xref_sine,
   input  wire logic        ring_osc_clk,
   input  wire logic        pfd_up,
   input  wire logic        pfd_dn,
   input  wire logic        ramp_busy,
   output logic             ser_data_out,
   output logic [23:0]      sweep_increment,
   output logic [23:0]      sweep_step_count,
   output logic [23:0]      sweep_dwell,
   output logic             aux_clk,
   output logic             dsm_ref_clk,
   output logic [2:0]       aux_delay,
   output logic             lock_detect,
   output logic             gp_output_pin_1,
   output logic             gp_output_pin_2,
   output logic             gp_output_pin_3,
   output logic             gp_output_pin_1_oe,
   output logic             gp_output_pin_2_oe,
   output logic             gp_output_pin_3_oe
);
   if (SYM_WIN_CYC < 1 || SYM_WIN_CYC > 254) begin : g_bad_win
      $error("SYM_WIN_CYC out of range");
   end

   typedef struct packed {
      pswr_pkg::pswr_pins_s s1;
      pswr_pkg::pswr_pins_s s2;
      pswr_pkg::pswr_pins_s s3;
      pswr_pkg::pswr_pins_s flt;
      pswr_pkg::pswr_pins_s flt_p;
      logic [23:0]          inc;
      logic [23:0]          cnt;
      logic [23:0]          dwell;
      logic [23:0]          auxa;
      logic [23:0]          auxb;
      logic [23:0]          lkd;
      logic [23:0]          gpo;
      logic [4:0]           bitcnt;
      logic [30:0]          shin;
      logic [23:0]          rd;
      logic                 rd_act;
      logic                 aux_lvl;
      logic [7:0]           div_cnt;
      logic [9:0]           lk_cnt;
      logic [7:0]           err_cnt;
      logic                 err_bad;
      logic                 locked;
      logic                 sdo;
      logic [2:0]           gpo_o;
      logic [2:0]           gpo_oe;
      logic                 dsm_clk;
      logic [2:0]           delay;
   } pswr_state_s;

   pswr_state_s          q;
   pswr_state_s          d;
   pswr_pkg::pswr_pins_s pins_in;
   logic                 sck_rise;
   logic                 sck_fall;
   logic                 ref_rise;
   logic                 ring_rise;
   logic                 src_now;
   logic                 src_old;
   logic                 src_rise;
   logic                 meas;
   logic                 wr_stb;
   logic [5:0]           wr_addr;
   logic [23:0]          wr_data;
   logic [23:0]          rd_word;
   logic [7:0]           div_max;
   logic [7:0]           win_c;
   logic [9:0]           thr;
   logic [2:0]           gsel;
   logic                 tick_c;
   logic                 lfsr_tick_c;

   pswr_mod_if mif ();

   pswr_dlymod pswr_dlymod_inst (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .m        (mif)
   );

   assign pins_in = '{sck: ser_clk, sen: ser_enable, sdi: ser_data_in, vco: vco_div_clk,
                      refc: ref_clk, xref: xref_clk, xsin: xref_sine, ring: ring_osc_clk,
                      up: pfd_up, dn: pfd_dn, busy: ramp_busy};

   function automatic logic pick_src(pswr_pkg::pswr_pins_s p, logic [1:0] sel, logic [1:0] path);
      logic s;
      s = 1'b0;
      unique case (sel)
         2'h0: s = p.vco;
         2'h1: s = p.xref;
         2'h2: s = p.refc;
         2'h3: s = p.ring;
      endcase
      // ring paths bypass the source mux entirely
      if (path[1]) begin
         s = p.ring;
      end
      return s;
   endfunction

   assign mif.tick      = tick_c;
   assign mif.lfsr_tick = lfsr_tick_c;
   assign mif.lfsr_en   = q.auxa[pswr_pkg::AUXA_LFSR];
   assign mif.accum_en  = q.auxa[pswr_pkg::AUXA_ACC];
   assign mif.mode      = q.auxa[pswr_pkg::AUXA_MODE +: 2];
   assign mif.step      = q.auxa[pswr_pkg::AUXA_STEP +: 8];
   assign mif.lodly     = q.auxa[pswr_pkg::AUXA_LODLY +: 3];
   assign mif.hidly     = q.auxb[pswr_pkg::AUXB_HIDLY +: 3];

   always_comb begin
      d = q;
      wr_stb = 1'b0;
      tick_c = 1'b0;
      lfsr_tick_c = 1'b0;
      gsel = 3'h0;
      rd_word = 24'h000000;

      // three stages; a change counts once stages two and three agree
      d.s1 = pins_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 | q.s3));
      d.flt_p = q.flt;
      sck_rise = q.flt.sck & ~q.flt_p.sck;
      sck_fall = ~q.flt.sck & q.flt_p.sck;
      ref_rise = q.flt.refc & ~q.flt_p.refc;
      ring_rise = q.flt.ring & ~q.flt_p.ring;

      // serial port: read flag, six address bits, 24 data bits, msb first
      if (!q.flt.sen) begin
         d.bitcnt = 5'h00;
         d.rd_act = 1'b0;
      end else begin
         if (sck_rise && q.bitcnt != pswr_pkg::FRAME_BITS) begin
            d.shin = {q.shin[29:0], q.flt.sdi};
            d.bitcnt = q.bitcnt + 5'h01;
         end
         if (sck_fall && q.rd_act && q.bitcnt > pswr_pkg::HDR_BITS) begin
            d.rd = {q.rd[22:0], 1'b0};
         end
      end
      wr_addr = d.shin[29:24];
      wr_data = d.shin[23:0];

      case (d.shin[5:0])
         pswr_pkg::ADDR_SWEEP_INC: rd_word = q.inc;
         pswr_pkg::ADDR_SWEEP_CNT: rd_word = q.cnt;
         pswr_pkg::ADDR_DWELL:     rd_word = q.dwell;
         pswr_pkg::ADDR_AUX_A:     rd_word = q.auxa;
         pswr_pkg::ADDR_AUX_B:     rd_word = q.auxb;
         pswr_pkg::ADDR_LOCK:      rd_word = q.lkd;
         pswr_pkg::ADDR_GPO:       rd_word = q.gpo;
         default:                  rd_word = 24'h000000;
      endcase

      if (q.flt.sen && sck_rise && q.bitcnt != pswr_pkg::FRAME_BITS) begin
         // forced lock routing owns the pin, so reads are never started
         if (d.bitcnt == pswr_pkg::HDR_BITS && d.shin[6] && !q.lkd[pswr_pkg::LKD_FIXED]) begin
            d.rd = rd_word;
            d.rd_act = 1'b1;
         end
         if (d.bitcnt == pswr_pkg::FRAME_BITS && !d.shin[30]) begin
            wr_stb = 1'b1;
         end
      end

      if (wr_stb) begin
         case (wr_addr)
            pswr_pkg::ADDR_SWEEP_INC: d.inc = wr_data;
            pswr_pkg::ADDR_SWEEP_CNT: d.cnt = wr_data;
            pswr_pkg::ADDR_DWELL:     d.dwell = wr_data;
            pswr_pkg::ADDR_AUX_A:     d.auxa = wr_data;
            pswr_pkg::ADDR_AUX_B:     d.auxb = wr_data;
            pswr_pkg::ADDR_LOCK:      d.lkd = wr_data;
            pswr_pkg::ADDR_GPO:       d.gpo = wr_data;
            default:                  d.gpo = q.gpo;
         endcase
      end

      // aux clock: selected source, divided by two to the power of the ratio field plus one
      src_now = pick_src(q.flt, q.auxa[pswr_pkg::AUXA_INSEL +: 2], q.auxa[pswr_pkg::AUXA_PATH +: 2]);
      src_old = pick_src(q.flt_p, q.auxa[pswr_pkg::AUXA_INSEL +: 2], q.auxa[pswr_pkg::AUXA_PATH +: 2]);
      src_rise = src_now & ~src_old;
      div_max = 8'((9'h001 << q.auxa[pswr_pkg::AUXA_DIV +: 3]) - 9'h001);
      if (src_rise) begin
         // >= keeps the divider safe when the ratio shrinks mid count
         if (q.div_cnt >= div_max) begin
            d.div_cnt = 8'h00;
            d.aux_lvl = ~q.aux_lvl;
            tick_c = d.aux_lvl ^ q.auxb[pswr_pkg::AUXB_INV];
         end else begin
            d.div_cnt = q.div_cnt + 8'h01;
         end
      end
      lfsr_tick_c = q.auxb[pswr_pkg::AUXB_RING] ? ring_rise : tick_c;
      d.dsm_clk = q.auxa[pswr_pkg::AUXA_DSMSEL] ? d.aux_lvl : q.flt.vco;
      d.delay = (q.auxa[pswr_pkg::AUXA_PATH +: 2] == 2'h0) ? 3'h0 : mif.delay;

      // lock detect: reference cycles whose phase error stays inside the window
      thr = q.lkd[pswr_pkg::LKD_THR +: 10];
      if (q.lkd[pswr_pkg::LKD_ASYM]) begin
         meas = q.lkd[pswr_pkg::LKD_POL] ? q.flt.up : q.flt.dn;
         win_c = 8'(pswr_pkg::ASYM_WIN_CYC);
      end else begin
         meas = q.flt.up | q.flt.dn;
         win_c = 8'(SYM_WIN_CYC);
      end
      if (ref_rise) begin
         if (q.err_bad) begin
            d.lk_cnt = 10'h000;
            d.locked = 1'b0;
         end else begin
            if (q.lk_cnt < thr) begin
               d.lk_cnt = q.lk_cnt + 10'h001;
            end
            d.locked = (d.lk_cnt >= thr);
         end
         d.err_cnt = 8'h00;
         d.err_bad = 1'b0;
      end else if (meas) begin
         if (q.err_cnt != 8'hFF) begin
            d.err_cnt = q.err_cnt + 8'h01;
         end
         if (q.err_cnt >= win_c) begin
            d.err_bad = 1'b1;
         end
      end

      // readout pin: forced lock, else read data, else idle lock
      if (q.lkd[pswr_pkg::LKD_FIXED]) begin
         d.sdo = d.locked;
      end else if (d.rd_act) begin
         d.sdo = d.rd[23];
      end else begin
         d.sdo = q.lkd[pswr_pkg::LKD_AUTO] & d.locked;
      end

      // general purpose pins; unsupported and reserved codes drive low
      case (q.gpo[pswr_pkg::GPO_SEL +: 4])
         pswr_pkg::GSEL_STATIC: gsel = q.gpo[pswr_pkg::GPO_STATIC +: 3];
         pswr_pkg::GSEL_CLOCKS: gsel = {q.flt.xref, q.flt.refc, q.flt.vco};
         pswr_pkg::GSEL_PFD:    gsel = {q.flt.up, q.flt.dn, ~q.err_bad};
         pswr_pkg::GSEL_XREF:   gsel = {q.flt.xref, q.flt.xsin, 1'b0};
         pswr_pkg::GSEL_AUX:    gsel = {q.aux_lvl, q.flt.ring, q.dsm_clk};
         pswr_pkg::GSEL_RAMP:   gsel = {1'b0, q.flt.busy, 1'b0};
         default:               gsel = 3'h0;
      endcase
      d.gpo_o = gsel;
      d.gpo_oe = {3{q.gpo[pswr_pkg::GPO_DRV]}} & ~q.gpo[pswr_pkg::GPO_DIS +: 3];
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.inc <= pswr_pkg::RST_SWEEP;
         q.cnt <= pswr_pkg::RST_SWEEP;
         q.dwell <= pswr_pkg::RST_SWEEP;
         q.auxa <= pswr_pkg::RST_AUX_A;
         q.auxb <= pswr_pkg::RST_AUX_B;
         q.lkd <= pswr_pkg::RST_LOCK;
         q.gpo <= pswr_pkg::RST_GPO;
      end else begin
         q <= d;
      end
   end

   assign ser_data_out       = q.sdo;
   assign sweep_increment    = q.inc;
   assign sweep_step_count   = q.cnt;
   assign sweep_dwell        = q.dwell;
   assign aux_clk            = q.aux_lvl;
   assign dsm_ref_clk        = q.dsm_clk;
   assign aux_delay          = q.delay;
   assign lock_detect        = q.locked;
   assign gp_output_pin_1    = q.gpo_o[0];
   assign gp_output_pin_2    = q.gpo_o[1];
   assign gp_output_pin_3    = q.gpo_o[2];
   assign gp_output_pin_1_oe = q.gpo_oe[0];
   assign gp_output_pin_2_oe = q.gpo_oe[1];
   assign gp_output_pin_3_oe = q.gpo_oe[2];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sweep_inc_wr_a: assert property (wr_stb && wr_addr == pswr_pkg::ADDR_SWEEP_INC
                                    |=> sweep_increment == $past(wr_data))
      else $error("sweep increment not written");
   sweep_cnt_wr_a: assert property (wr_stb && wr_addr == pswr_pkg::ADDR_SWEEP_CNT
                                    |=> sweep_step_count == $past(wr_data))
      else $error("sweep step count not written");
   dwell_wr_a: assert property (wr_stb && wr_addr == pswr_pkg::ADDR_DWELL
                                |=> sweep_dwell == $past(wr_data))
      else $error("dwell not written");
   aux_div_a: assert property (src_rise && q.div_cnt >= div_max |=> aux_clk != $past(aux_clk))
      else $error("aux divider missed its terminal count");
   dsm_sel_a: assert property (q.auxa[pswr_pkg::AUXA_DSMSEL] |=> dsm_ref_clk == aux_clk)
      else $error("modulator clock not from aux clock");
   lock_set_a: assert property (ref_rise && !q.err_bad && q.lk_cnt >= thr |=> lock_detect)
      else $error("lock not declared at threshold");
   lock_drop_a: assert property (ref_rise && q.err_bad |=> !lock_detect ##1 q.lk_cnt == 10'h000)
      else $error("lock kept after bad window");
   sdo_auto_a: assert property (q.lkd[pswr_pkg::LKD_AUTO] && !q.lkd[pswr_pkg::LKD_FIXED]
                                && !q.flt.sen |=> ser_data_out == lock_detect)
      else $error("idle readout pin not lock");
   sdo_fixed_a: assert property (q.lkd[pswr_pkg::LKD_FIXED]
                                 |=> ser_data_out == lock_detect && !q.rd_act)
      else $error("forced lock routing broken");
   gpo_static_a: assert property (q.gpo[pswr_pkg::GPO_SEL +: 4] == pswr_pkg::GSEL_STATIC
                                  |=> {gp_output_pin_3, gp_output_pin_2, gp_output_pin_1}
                                      == $past(q.gpo[pswr_pkg::GPO_STATIC +: 3]))
      else $error("static pin value wrong");
   gpo_off_a: assert property (!q.gpo[pswr_pkg::GPO_DRV]
                               |=> {gp_output_pin_3_oe, gp_output_pin_2_oe, gp_output_pin_1_oe} == 3'h0)
      else $error("pads driven while disabled");
   gpo_mask_a: assert property (q.gpo[pswr_pkg::GPO_DRV]
                                |=> {gp_output_pin_3_oe, gp_output_pin_2_oe, gp_output_pin_1_oe}
                                    == ~$past(q.gpo[pswr_pkg::GPO_DIS +: 3]))
      else $error("pad mask not applied");

   read_frame_c: cover property (q.rd_act && q.bitcnt == pswr_pkg::FRAME_BITS);
   write_frame_c: cover property (wr_stb);
   lock_gain_c: cover property (!lock_detect ##1 lock_detect);
endmodule
`default_nettype wire

// >>> test/pswr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pswr_host (
   input  wire logic core_clk,
   input  wire logic ser_data_out,
   output logic      ser_clk,
   output logic      ser_enable,
   output logic      ser_data_in
);
   initial begin
      ser_clk = 1'b0;
      ser_enable = 1'b0;
      ser_data_in = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // read flag, address, data; readout sampled just before rises 8..31
   task automatic frame(input logic rd, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
      logic [30:0] bits;
      bits = {rd, a, d};
      q = 24'h000000;
      wait_cyc(1);
      ser_enable = 1'b1;
      for (int i = 30; i >= 0; i--) begin
         ser_data_in = bits[i];
         wait_cyc(10);
         if (i <= 23) q = {q[22:0], ser_data_out};
         ser_clk = 1'b1;
         wait_cyc(10);
         ser_clk = 1'b0;
      end
      wait_cyc(10);
      ser_enable = 1'b0;
      // released data line does not keep its last level
      ser_data_in = ~ser_data_in;
      wait_cyc(12);
   endtask
endmodule
`default_nettype wire

// >>> test/pswr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pswr_regs_bench;
   typedef struct {logic [5:0] a; logic [23:0] rst; logic [23:0] wr; logic [23:0] rb;} pswr_row_s;
   logic        core_clk, rst_b, vco_div_clk, ref_clk, xref_clk, xref_sine, ring_osc_clk;
   logic        pfd_up, pfd_dn, ramp_busy;
   wire         ser_clk, ser_enable, ser_data_in, ser_data_out, aux_clk, dsm_ref_clk, lock_detect;
   wire  [2:0]  aux_delay, pin, oe;
   wire  [23:0] sweep_increment, sweep_step_count, sweep_dwell;
   logic [23:0] q;
   logic [29:0] gcase [7];
   pswr_row_s   rows [8];
   int          fails, n_checks;
   pswr_regs #(.SYM_WIN_CYC(2)) pswr_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .ser_clk(ser_clk),
      .ser_enable(ser_enable), .ser_data_in(ser_data_in), .vco_div_clk(vco_div_clk), .ref_clk(ref_clk),
      .xref_clk(xref_clk), .xref_sine(xref_sine), .ring_osc_clk(ring_osc_clk), .pfd_up(pfd_up),
      .pfd_dn(pfd_dn), .ramp_busy(ramp_busy), .ser_data_out(ser_data_out), .sweep_increment(sweep_increment),
      .sweep_step_count(sweep_step_count), .sweep_dwell(sweep_dwell), .aux_clk(aux_clk),
      .dsm_ref_clk(dsm_ref_clk), .aux_delay(aux_delay), .lock_detect(lock_detect),
      .gp_output_pin_1(pin[0]), .gp_output_pin_2(pin[1]), .gp_output_pin_3(pin[2]),
      .gp_output_pin_1_oe(oe[0]), .gp_output_pin_2_oe(oe[1]), .gp_output_pin_3_oe(oe[2]));
   pswr_host pswr_host_inst (.core_clk(core_clk), .ser_data_out(ser_data_out), .ser_clk(ser_clk),
      .ser_enable(ser_enable), .ser_data_in(ser_data_in));
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d);
      pswr_host_inst.frame(1'b1, a, 24'h000000, d);
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      logic [23:0] dummy;
      pswr_host_inst.frame(1'b0, a, d, dummy);
   endtask
   // slow reference so the synchronisers see every edge
   task automatic pulse(input int n);
      repeat (n) begin
         ref_clk = 1'b1;
         step(6);
         ref_clk = 1'b0;
         step(6);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      step(60000);
      fails++;
      close_out();
   end
   initial begin
      {rst_b, vco_div_clk, ref_clk, xref_clk, xref_sine, ring_osc_clk, pfd_up, pfd_dn, ramp_busy} = 9'h000;
      fails = 0;
      n_checks = 0;
      // sweep span kept well inside the allowed range
      rows[0] = '{pswr_pkg::ADDR_SWEEP_INC, 24'h000800, 24'h123456, 24'h123456};
      rows[1] = '{pswr_pkg::ADDR_SWEEP_CNT, 24'h000800, 24'h000010, 24'h000010};
      rows[2] = '{pswr_pkg::ADDR_DWELL, 24'h000800, 24'hABCDEF, 24'hABCDEF};
      rows[3] = '{pswr_pkg::ADDR_AUX_A, 24'h0000A0, 24'h3456A5, 24'h3456A5};
      rows[4] = '{pswr_pkg::ADDR_AUX_B, 24'h00000F, 24'h000015, 24'h000015};
      rows[5] = '{pswr_pkg::ADDR_LOCK, 24'h001040, 24'h0013FF, 24'h0013FF};
      rows[6] = '{pswr_pkg::ADDR_GPO, 24'h000000, 24'h0007B5, 24'h0007B5};
      rows[7] = '{6'h14, 24'h000000, 24'h5A5A5A, 24'h000000};
      // register value, expected pins 3..1, expected enables 3..1
      gcase = '{{24'h0002D0, 6'o55}, {24'h000050, 6'o50}, {24'h000081, 6'o57},
                {24'h000088, 6'o27}, {24'h000085, 6'o07}, {24'h000084, 6'o47},
                {24'h000082, 6'o17}};
      step(8);
      chk_reg(sweep_dwell, 24'h000800);
      chk_pin({lock_detect, ser_data_out, oe[0]}, 3'h0);
      rst_b = 1'b1;
      step(8);
      $display("reset test done");
      foreach (rows[i]) begin
         rd(rows[i].a, q);
         chk_reg(q, rows[i].rst);
         wr(rows[i].a, rows[i].wr);
         rd(rows[i].a, q);
         chk_reg(q, rows[i].rb);
      end
      chk_reg(sweep_increment, 24'h123456);
      chk_reg(sweep_step_count, 24'h000010);
      chk_reg(sweep_dwell, 24'hABCDEF);
      $display("register rows done");
      wr(pswr_pkg::ADDR_LOCK, 24'h001004);
      pulse(3);
      chk_pin({2'b00, lock_detect}, 3'h0);
      pulse(1);
      chk_pin({1'b0, lock_detect, ser_data_out}, 3'h3);
      pfd_up = 1'b1;
      step(5);
      pfd_up = 1'b0;
      pulse(1);
      chk_pin({2'b00, lock_detect}, 3'h0);
      wr(pswr_pkg::ADDR_LOCK, 24'h001C04);
      pulse(4);
      pfd_dn = 1'b1;
      step(5);
      pfd_dn = 1'b0;
      pulse(1);
      chk_pin({2'b00, lock_detect}, 3'h1);
      wr(pswr_pkg::ADDR_LOCK, 24'h003C04);
      rd(pswr_pkg::ADDR_LOCK, q);
      chk_reg(q, 24'hFFFFFF);
      wr(pswr_pkg::ADDR_LOCK, 24'h000C04);
      chk_pin({2'b00, ser_data_out}, 3'h0);
      rd(pswr_pkg::ADDR_LOCK, q);
      chk_reg(q, 24'h000C04);
      $display("lock test done");
      {xref_clk, vco_div_clk, ramp_busy} = 3'h7;
      foreach (gcase[i]) begin
         wr(pswr_pkg::ADDR_GPO, gcase[i][29:6]);
         step(2);
         chk_pin(pin, gcase[i][5:3]);
         chk_pin(oe, gcase[i][2:0]);
      end
      $display("output pin test done");
      rst_b = 1'b0;
      step(2);
      chk_reg(sweep_increment, 24'h000800);
      rst_b = 1'b1;
      step(8);
      rd(pswr_pkg::ADDR_GPO, q);
      chk_reg(q, 24'h000000);
      $display("second reset test done");
      // reference as aux source, ratio field 0 so every reference rise toggles
      wr(pswr_pkg::ADDR_AUX_A, 24'h500D86);
      chk_pin(aux_delay, 3'h1);
      pulse(1);
      chk_pin({1'b0, aux_clk, dsm_ref_clk}, 3'h3);
      pulse(1);
      chk_pin({1'b0, aux_clk, dsm_ref_clk}, 3'h0);
      chk_pin(aux_delay, 3'h2);
      wr(pswr_pkg::ADDR_AUX_A, 24'h500006);
      chk_pin(aux_delay, 3'h5);
      chk_pin({1'b0, aux_clk, dsm_ref_clk}, 3'h1);
      wr(pswr_pkg::ADDR_AUX_A, 24'h500002);
      chk_pin(aux_delay, 3'h0);
      $display("aux clock test done");
      close_out();
   end
endmodule
`default_nettype wire
